// ==== common/timer_pkg.sv ====
// Package for the reloading timer: register addresses, control bit positions,
// divider figures and the packed carriers shared by the timer and its prescaler.
// Assumes a byte-wide special-function register bus with single-cycle strobes.
package timer_pkg;

    // Special-function register addresses.
    localparam logic [7:0] ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LO = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HI = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LO = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HI = 8'hcd;

    // Bit positions inside the control register.
    localparam logic [2:0] BIT_HIGH_FLAG = 3'h7;
    localparam logic [2:0] BIT_LOW_FLAG = 3'h6;
    localparam logic [2:0] BIT_LOW_IRQ_EN = 3'h5;
    localparam logic [2:0] BIT_SPLIT = 3'h3;
    localparam logic [2:0] BIT_RUN = 3'h2;
    localparam logic [2:0] BIT_XCLK = 3'h0;

    // Count limits.
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    // Prescaler figures.
    localparam int SYS_DIVIDE = 12;
    localparam int EXT_DIVIDE = 8;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);
    localparam logic [3:0] SYS_DIV_ONE = 4'h1;
    localparam logic [2:0] EXT_DIV_ONE = 3'h1;

    // One register bus request; bit_wr writes wdata[0] to the bit addressed.
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic [3:0] sys_cnt;
        logic [2:0] ext_cnt;
        logic ext_sync1;
        logic ext_sync2;
        logic ext_prev;
        logic tick_div12;
        logic tick_ext8;
    } prescale_state_t;

    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic split_mode_select;
        logic run_control;
        logic external_clock_select;
        logic [7:0] reload_low_byte;
        logic [7:0] reload_high_byte;
        logic [7:0] counter_low_byte;
        logic [7:0] counter_high_byte;
        logic [7:0] rdata;
    } timer_state_t;

    localparam prescale_state_t PRESCALE_RESET = '0;
    localparam timer_state_t TIMER_RESET = '0;

endpackage : timer_pkg

// ==== verilog/timer_prescaler.sv ====
// Prescaler for the reloading timer: one-cycle ticks at the system clock
// divided by 12 and at the external oscillator divided by 8.
// Assumes rst_n is already synchronous to clk_sys.
`timescale 1ns/100ps
module timer_prescaler (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ext_clk,
    output logic tick_div12,
    output logic tick_ext8
);
    timer_pkg::prescale_state_t s_q;
    timer_pkg::prescale_state_t s_d;
    logic ext_rise;

    always_comb begin
        s_d = s_q;
        s_d.tick_div12 = 1'b0;
        s_d.tick_ext8 = 1'b0;
        if (s_q.sys_cnt == timer_pkg::SYS_DIV_LAST) begin
            s_d.sys_cnt = '0;
            s_d.tick_div12 = 1'b1;
        end else begin
            s_d.sys_cnt = s_q.sys_cnt + timer_pkg::SYS_DIV_ONE;
        end
        // The oscillator is brought in through two flops before its edges count.
        s_d.ext_sync1 = ext_clk;
        s_d.ext_sync2 = s_q.ext_sync1;
        s_d.ext_prev = s_q.ext_sync2;
        ext_rise = s_q.ext_sync2 && !s_q.ext_prev;
        if (ext_rise) begin
            s_d.ext_cnt = s_q.ext_cnt + timer_pkg::EXT_DIV_ONE;
            s_d.tick_ext8 = (s_q.ext_cnt == timer_pkg::EXT_DIV_LAST);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= timer_pkg::PRESCALE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_div12 = s_q.tick_div12;
    assign tick_ext8 = s_q.tick_ext8;

endmodule : timer_prescaler

// ==== verilog/reload_timer.sv ====
// Reloading timer: one 16-bit counter or two 8-bit counters, each reloading
// from its own reload byte, with sticky overflow flags and one interrupt request.
// Assumes a byte-wide register bus synchronous to clk_sys; the timer interrupt
// enable and the per-byte clock selects arrive as plain levels from elsewhere.
//
// Notes on behaviour
// (R1) Control bit 3 picks 16-bit or split.
// (R2) Clocks: system, system/12, external/8 synchronised.
// (R3) 16-bit rollover loads reload, sets high flag.
// (R4) 16-bit overflow requests interrupt when enabled.
// (R5) Low-byte rollover also interrupts when enabled.
// (R6) Split: each byte reloads from its byte.
// (R7) Split: run gates high byte only.
// (R8) Per-byte select: system clock, else external select.
// (R9) Split: high byte rollover sets high flag.
// (R10) Low byte rollover sets low flag always.
// (R11) Split interrupts on high, optionally either byte.
// (R12) Flags cleared only by software writes.
// (R13) Software reads both flags to find source.
// (R14) Control register at 0xc8, bit-addressable, resets zero.
// (R15) External select: 0 system/12, 1 external/8.
// (R16) Bits 4 and 1 read zero, ignore writes.
// (R17) Run one counts, zero holds the value; in split mode it holds only the high byte.
// (R18) Request level follows enabled flags.
// (R19) Software counter write beats count or reload.
`timescale 1ns/100ps
module reload_timer (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire timer_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic timer_irq_enable,
    input wire logic high_byte_system_clock_select,
    input wire logic low_byte_system_clock_select,
    input wire logic ext_clk,
    output logic irq_request
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic tick_div12;
    logic tick_ext8;
    logic tick_lo;
    logic tick_hi;
    logic set_high;
    logic set_low;
    logic wr_ctrl;
    logic [15:0] count16;
    logic [15:0] reload16;
    timer_pkg::timer_state_t s_q;
    timer_pkg::timer_state_t s_d;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // (R2) Divided clock ticks.
    timer_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ext_clk(ext_clk),
        .tick_div12(tick_div12),
        .tick_ext8(tick_ext8)
    );

    function automatic logic pick_tick(input logic sys_sel, input logic xclk,
                                       input logic div12, input logic ext8);
        // (R15) External select picks the divided source.
        pick_tick = sys_sel ? 1'b1 : (xclk ? ext8 : div12);
    endfunction : pick_tick

    // (R8) Per-byte clock selection.
    assign tick_lo = pick_tick(low_byte_system_clock_select, s_q.external_clock_select,
                               tick_div12, tick_ext8);
    assign tick_hi = pick_tick(high_byte_system_clock_select, s_q.external_clock_select,
                               tick_div12, tick_ext8);
    assign count16 = {s_q.counter_high_byte, s_q.counter_low_byte};
    assign reload16 = {s_q.reload_high_byte, s_q.reload_low_byte};
    assign wr_ctrl = (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_CONTROL)
                     || (sfr_req.bit_wr && sfr_req.addr[7:3] == timer_pkg::ADDR_CONTROL[7:3]);

    always_comb begin
        s_d = s_q;
        set_high = 1'b0;
        set_low = 1'b0;
        // (R1) Mode choice by split bit.
        if (!s_q.split_mode_select) begin
            // (R17) Run gates the whole word.
            if (s_q.run_control && tick_lo) begin
                if (count16 == timer_pkg::WORD_MAX) begin
                    // (R3) Word rollover reloads.
                    {s_d.counter_high_byte, s_d.counter_low_byte} = reload16;
                    set_high = 1'b1;
                    set_low = 1'b1;
                end else begin
                    {s_d.counter_high_byte, s_d.counter_low_byte} = count16 + timer_pkg::WORD_ONE;
                    // (R10) Low byte rollover flagged.
                    set_low = (s_q.counter_low_byte == timer_pkg::BYTE_MAX);
                end
            end
        end else begin
            // (R7) Low byte always runs.
            if (tick_lo) begin
                // (R6) Low byte reloads alone.
                if (s_q.counter_low_byte == timer_pkg::BYTE_MAX) begin
                    s_d.counter_low_byte = s_q.reload_low_byte;
                    set_low = 1'b1;
                end else begin
                    s_d.counter_low_byte = s_q.counter_low_byte + timer_pkg::BYTE_ONE;
                end
            end
            if (s_q.run_control && tick_hi) begin
                // (R9) High byte rollover flagged.
                if (s_q.counter_high_byte == timer_pkg::BYTE_MAX) begin
                    s_d.counter_high_byte = s_q.reload_high_byte;
                    set_high = 1'b1;
                end else begin
                    s_d.counter_high_byte = s_q.counter_high_byte + timer_pkg::BYTE_ONE;
                end
            end
        end
        // (R19) Software writes override the count.
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                timer_pkg::ADDR_CONTROL: begin
                    // (R16) Bits 4 and 1 are not stored.
                    s_d.high_overflow_flag = sfr_req.wdata[timer_pkg::BIT_HIGH_FLAG];
                    s_d.low_overflow_flag = sfr_req.wdata[timer_pkg::BIT_LOW_FLAG];
                    s_d.low_overflow_irq_enable = sfr_req.wdata[timer_pkg::BIT_LOW_IRQ_EN];
                    s_d.split_mode_select = sfr_req.wdata[timer_pkg::BIT_SPLIT];
                    s_d.run_control = sfr_req.wdata[timer_pkg::BIT_RUN];
                    s_d.external_clock_select = sfr_req.wdata[timer_pkg::BIT_XCLK];
                end
                timer_pkg::ADDR_RELOAD_LO: s_d.reload_low_byte = sfr_req.wdata;
                timer_pkg::ADDR_RELOAD_HI: s_d.reload_high_byte = sfr_req.wdata;
                timer_pkg::ADDR_COUNT_LO: s_d.counter_low_byte = sfr_req.wdata;
                timer_pkg::ADDR_COUNT_HI: s_d.counter_high_byte = sfr_req.wdata;
                default: begin
                end
            endcase
        end
        // (R14) Single-bit writes to the control register.
        if (sfr_req.bit_wr && sfr_req.addr[7:3] == timer_pkg::ADDR_CONTROL[7:3]) begin
            case (sfr_req.addr[2:0])
                timer_pkg::BIT_HIGH_FLAG: s_d.high_overflow_flag = sfr_req.wdata[0];
                timer_pkg::BIT_LOW_FLAG: s_d.low_overflow_flag = sfr_req.wdata[0];
                timer_pkg::BIT_LOW_IRQ_EN: s_d.low_overflow_irq_enable = sfr_req.wdata[0];
                timer_pkg::BIT_SPLIT: s_d.split_mode_select = sfr_req.wdata[0];
                timer_pkg::BIT_RUN: s_d.run_control = sfr_req.wdata[0];
                timer_pkg::BIT_XCLK: s_d.external_clock_select = sfr_req.wdata[0];
                default: begin
                end
            endcase
        end
        // (R12) Hardware only sets; a set beats a clear.
        s_d.high_overflow_flag = s_d.high_overflow_flag | set_high;
        s_d.low_overflow_flag = s_d.low_overflow_flag | set_low;
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                timer_pkg::ADDR_CONTROL: s_d.rdata = {s_q.high_overflow_flag,
                    s_q.low_overflow_flag, s_q.low_overflow_irq_enable, 1'b0,
                    s_q.split_mode_select, s_q.run_control, 1'b0,
                    s_q.external_clock_select};
                timer_pkg::ADDR_RELOAD_LO: s_d.rdata = s_q.reload_low_byte;
                timer_pkg::ADDR_RELOAD_HI: s_d.rdata = s_q.reload_high_byte;
                timer_pkg::ADDR_COUNT_LO: s_d.rdata = s_q.counter_low_byte;
                timer_pkg::ADDR_COUNT_HI: s_d.rdata = s_q.counter_high_byte;
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= timer_pkg::TIMER_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata = s_q.rdata;
    // (R4) (R5) (R11) (R18) Shared request level.
    assign irq_request = timer_irq_enable && (s_q.high_overflow_flag
                         || (s_q.low_overflow_flag && s_q.low_overflow_irq_enable));

    logic wr_lo;
    logic wr_hi;
    assign wr_lo = sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_COUNT_LO;
    assign wr_hi = sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_COUNT_HI;

    // (R3) Word rollover reload.
    a_word_reload: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R3)
        (!s_q.split_mode_select && s_q.run_control && tick_lo && count16 == 16'hffff
         && !wr_lo && !wr_hi && !wr_ctrl)
        |=> (count16 == $past(reload16)) && s_q.high_overflow_flag && s_q.low_overflow_flag)
        else $error("word rollover did not reload and flag");

    // (R17) Halted counter holds.
    a_halt_holds: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R17)
        (!s_q.split_mode_select && !s_q.run_control && !wr_lo && !wr_hi && !wr_ctrl)
        |=> $stable(count16))
        else $error("halted counter moved");

    // (R7) Split low byte ignores run.
    a_split_low_runs: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R7)
        (s_q.split_mode_select && !s_q.run_control && low_byte_system_clock_select
         && s_q.counter_low_byte != 8'hff && !wr_lo && !wr_ctrl)
        |=> s_q.counter_low_byte == $past(s_q.counter_low_byte) + 8'h01)
        else $error("split low byte did not count");

    // (R6) Split low byte reload.
    a_split_low_reload: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R6)
        (s_q.split_mode_select && tick_lo && s_q.counter_low_byte == 8'hff && !wr_lo && !wr_ctrl)
        |=> s_q.counter_low_byte == $past(s_q.reload_low_byte) && s_q.low_overflow_flag)
        else $error("split low byte did not reload");

    // (R9) Split high rollover flags.
    a_split_high_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R9)
        (s_q.split_mode_select && s_q.run_control && tick_hi
         && s_q.counter_high_byte == 8'hff && !wr_hi && !wr_ctrl)
        |=> s_q.high_overflow_flag && s_q.counter_high_byte == $past(s_q.reload_high_byte))
        else $error("split high rollover missed");

    // (R11) Split high overflow requests.
    a_split_irq: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R11)
        (s_q.split_mode_select && s_q.run_control && tick_hi && timer_irq_enable
         && s_q.counter_high_byte == 8'hff && !wr_ctrl) ##1 timer_irq_enable
        |-> irq_request)
        else $error("split overflow gave no request");

    // (R5) Low rollover request when enabled.
    a_low_irq: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R5)
        (set_low && !wr_ctrl) ##1 (s_q.low_overflow_irq_enable && timer_irq_enable)
        |-> irq_request)
        else $error("low rollover gave no request");

    // (R12) High flag stays until written.
    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R12)
        (s_q.high_overflow_flag && !wr_ctrl) |=> s_q.high_overflow_flag)
        else $error("high flag cleared by hardware");

    // (R16) Unused bits read zero.
    a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R16)
        (sfr_req.rd && sfr_req.addr == timer_pkg::ADDR_CONTROL)
        |=> sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0)
        else $error("unused control bit read as one");

    // (R19) Write wins over count.
    a_write_wins: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R19)
        wr_lo |=> s_q.counter_low_byte == $past(sfr_req.wdata))
        else $error("counter write lost");

    // (R2) Eight quiet cycles after each divide-by-12 tick.
    a_div12_gap: assert property (@(posedge clk_sys) disable iff (!rst_n) // (R2)
        tick_div12 |=> (!tick_div12) [*8])
        else $error("system divider tick too soon");

    c_word_over: cover property (@(posedge clk_sys) disable iff (!rst_n)
        !s_q.split_mode_select && s_q.run_control && tick_lo && count16 == 16'hffff);
    c_split_both: cover property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.split_mode_select && set_low && set_high);
    c_irq_rise: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq_request));

endmodule : reload_timer

// ==== testbench/reload_timer_tb.sv ====
// Self-checking bench for the reloading timer, driving its register bus directly.
// Assumes the timer package is compiled first and the bus takes one request per strobe.
`timescale 1ns/100ps
module reload_timer_tb;
    logic clk_sys;
    logic resetn;
    timer_pkg::sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic timer_irq_enable;
    logic high_byte_system_clock_select;
    logic low_byte_system_clock_select;
    logic ext_clk;
    logic irq_request;
    int num_errors;
    int num_checks;
    logic [7:0] rd_val;

    reload_timer reload_timer_i (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata),
        .timer_irq_enable(timer_irq_enable),
        .high_byte_system_clock_select(high_byte_system_clock_select),
        .low_byte_system_clock_select(low_byte_system_clock_select),
        .ext_clk(ext_clk),
        .irq_request(irq_request)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // The oscillator runs free at 25 MHz, offset so its edges never meet the system clock.
    initial begin
        ext_clk = 1'b0;
        #3;
        forever #20 ext_clk = ~ext_clk;
    end

    task automatic complete_run();
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One request held from just after an edge through the edge that takes it.
    task automatic bus(input logic rd, input logic wr, input logic bw,
                       input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk_sys);
        #1 sfr_req = '{rd: rd, wr: wr, bit_wr: bw, addr: addr, wdata: wdata};
        @(posedge clk_sys);
        #1 sfr_req = '0;
    endtask : bus

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        bus(1'b0, 1'b1, 1'b0, addr, data);
    endtask : wr

    task automatic bit_wr(input logic [2:0] bitn, input logic val);
        bus(1'b0, 1'b0, 1'b1, timer_pkg::ADDR_CONTROL + 8'(bitn), {7'h00, val});
    endtask : bit_wr

    task automatic rd(input logic [7:0] addr);
        bus(1'b1, 1'b0, 1'b0, addr, 8'h00);
        @(posedge clk_sys);
        #1 rd_val = sfr_rdata;
    endtask : rd

    task automatic load(input logic [7:0] rl_lo, input logic [7:0] rl_hi,
                        input logic [7:0] c_lo, input logic [7:0] c_hi);
        wr(timer_pkg::ADDR_RELOAD_LO, rl_lo);
        wr(timer_pkg::ADDR_RELOAD_HI, rl_hi);
        wr(timer_pkg::ADDR_COUNT_LO, c_lo);
        wr(timer_pkg::ADDR_COUNT_HI, c_hi);
    endtask : load

    task automatic t_reset_values();
        rd(timer_pkg::ADDR_CONTROL); check(rd_val, 8'h00);
        for (int a = 8'hca; a <= 8'hcd; a++) begin
            rd(8'(a)); check(rd_val, 8'h00);
        end
        rd(8'hc9); check(rd_val, 8'h00);
    endtask : t_reset_values

    task automatic t_control_bits();
        wr(timer_pkg::ADDR_CONTROL, 8'hff);
        rd(timer_pkg::ADDR_CONTROL); check(rd_val, 8'hed);
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
        bit_wr(3'h4, 1'b1);
        bit_wr(3'h1, 1'b1);
        bit_wr(timer_pkg::BIT_SPLIT, 1'b1);
        rd(timer_pkg::ADDR_CONTROL); check(rd_val, 8'h08);
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
    endtask : t_control_bits

    task automatic t_word_overflow();
        low_byte_system_clock_select = 1'b1;
        timer_irq_enable = 1'b1;
        load(8'hf0, 8'hff, 8'hfe, 8'hff);
        // The low-byte request is enabled while the word rolls over.
        wr(timer_pkg::ADDR_CONTROL, 8'h24);
        repeat (3) @(posedge clk_sys);
        bit_wr(timer_pkg::BIT_RUN, 1'b0);
        rd(timer_pkg::ADDR_COUNT_LO); check(rd_val, 8'hf3);
        rd(timer_pkg::ADDR_COUNT_HI); check(rd_val, 8'hff);
        rd(timer_pkg::ADDR_CONTROL); check(rd_val, 8'he0);
        check({7'h00, irq_request}, 8'h01);
        #10 timer_irq_enable = 1'b0;
        #10 check({7'h00, irq_request}, 8'h00);
        timer_irq_enable = 1'b1;
        bit_wr(timer_pkg::BIT_HIGH_FLAG, 1'b0);
        check({7'h00, irq_request}, 8'h01);
        rd(timer_pkg::ADDR_CONTROL); check(rd_val, 8'h60);
        bit_wr(timer_pkg::BIT_LOW_IRQ_EN, 1'b0);
        check({7'h00, irq_request}, 8'h00);
        bit_wr(timer_pkg::BIT_LOW_IRQ_EN, 1'b1);
        check({7'h00, irq_request}, 8'h01);
        bit_wr(timer_pkg::BIT_LOW_FLAG, 1'b0);
        check({7'h00, irq_request}, 8'h00);
        wr(timer_pkg::ADDR_CONTROL, 8'h04);
        wr(timer_pkg::ADDR_COUNT_LO, 8'h55);
        bit_wr(timer_pkg::BIT_RUN, 1'b0);
        rd(timer_pkg::ADDR_COUNT_LO); check(rd_val, 8'h57);
    endtask : t_word_overflow

    task automatic t_split();
        high_byte_system_clock_select = 1'b1;
        load(8'h10, 8'h20, 8'hfe, 8'hfe);
        wr(timer_pkg::ADDR_CONTROL, 8'h08);
        repeat (3) @(posedge clk_sys);
        bit_wr(timer_pkg::BIT_SPLIT, 1'b0);
        rd(timer_pkg::ADDR_COUNT_LO); check(rd_val, 8'h13);
        rd(timer_pkg::ADDR_COUNT_HI); check(rd_val, 8'hfe);
        rd(timer_pkg::ADDR_CONTROL); check(rd_val, 8'h40);
        check({7'h00, irq_request}, 8'h00);
        bit_wr(timer_pkg::BIT_LOW_IRQ_EN, 1'b1);
        check({7'h00, irq_request}, 8'h01);
        wr(timer_pkg::ADDR_CONTROL, 8'h0c);
        repeat (3) @(posedge clk_sys);
        bit_wr(timer_pkg::BIT_RUN, 1'b0);
        rd(timer_pkg::ADDR_COUNT_HI); check(rd_val, 8'h23);
        rd(timer_pkg::ADDR_CONTROL); check(rd_val & 8'h80, 8'h80);
        check({7'h00, irq_request}, 8'h01);
        high_byte_system_clock_select = 1'b0;
        wr(timer_pkg::ADDR_COUNT_HI, 8'h00);
        wr(timer_pkg::ADDR_CONTROL, 8'h0c);
        repeat (118) @(posedge clk_sys);
        bit_wr(timer_pkg::BIT_RUN, 1'b0);
        rd(timer_pkg::ADDR_COUNT_HI); check(rd_val, 8'h0a);
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
    endtask : t_split

    task automatic t_prescale();
        low_byte_system_clock_select = 1'b0;
        load(8'h00, 8'h00, 8'h00, 8'h00);
        wr(timer_pkg::ADDR_CONTROL, 8'h04);
        repeat (118) @(posedge clk_sys);
        bit_wr(timer_pkg::BIT_RUN, 1'b0);
        rd(timer_pkg::ADDR_COUNT_LO); check(rd_val, 8'h0a);
        wr(timer_pkg::ADDR_COUNT_LO, 8'h00);
        wr(timer_pkg::ADDR_CONTROL, 8'h05);
        repeat (958) @(posedge clk_sys);
        bit_wr(timer_pkg::BIT_RUN, 1'b0);
        // The oscillator is exactly four system cycles, so 960 counting edges give 30 ticks.
        rd(timer_pkg::ADDR_COUNT_LO); check(rd_val, 8'h1e);
    endtask : t_prescale

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        complete_run();
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        resetn = 1'b0;
        sfr_req = '0;
        timer_irq_enable = 1'b0;
        high_byte_system_clock_select = 1'b0;
        low_byte_system_clock_select = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset_values();
        t_control_bits();
        t_word_overflow();
        t_split();
        t_prescale();
        complete_run();
    end
endmodule : reload_timer_tb
